//--- src/rswk_pkg.sv
/*
  Package for the reset distribution and stop-mode wake block: reset source
  codes, domain bit positions, wake source positions and sizes.
  Assumes nothing of its surroundings; imported by no file, used by scope.
*/
package rswk_pkg;

  // Reset source indices in the request vector
  localparam int SRC_POR    = 0;
  localparam int SRC_LVD    = 1;
  localparam int SRC_LLWAKE = 2;
  localparam int SRC_PIN    = 3;
  localparam int SRC_WDOG   = 4;
  localparam int SRC_SACK   = 5;
  localparam int SRC_SW     = 6;
  localparam int SRC_LOCKUP = 7;
  localparam int SRC_DAP    = 8;
  localparam int SRC_DEBUG  = 9;
  localparam int NUM_SRC    = 10;

  // Domain indices in the full and partial reset vectors
  localparam int DOM_PWR    = 0;
  localparam int DOM_SYS    = 1;
  localparam int DOM_MODE   = 2;
  localparam int DOM_RST    = 3;
  localparam int DOM_WAKE   = 4;
  localparam int DOM_RTC    = 5;
  localparam int DOM_LOW_POWER_TIMER  = 6;
  localparam int DOM_OTHER  = 7;
  localparam int NUM_DOM    = 8;

  // Wake source indices
  localparam int WK_PIN     = 0;
  localparam int WK_WDOG    = 1;
  localparam int WK_LVD     = 2;
  localparam int WK_LVW     = 3;
  localparam int WK_PORT    = 4;
  localparam int WK_ADC     = 5;
  localparam int WK_CMP     = 6;
  localparam int WK_RTC_ALM = 7;
  localparam int WK_RTC_SEC = 8;
  localparam int WK_SERIAL  = 9;
  localparam int WK_TIMER   = 10;
  localparam int WK_LOW_POWER_TIMER   = 11;
  localparam int WK_FLEX    = 12;
  localparam int WK_USB     = 13;
  localparam int NUM_WK     = 14;

  // Scratch register file: 32 bytes as 8 words of 32 bits
  localparam int SRF_BYTES  = 32;
  localparam int SRF_DW     = 32;
  localparam int SRF_WORDS  = SRF_BYTES / (SRF_DW / 8);
  localparam int SRF_AW     = $clog2(SRF_WORDS);
  localparam logic [SRF_DW-1:0] SRF_RESET = 32'h0000_0000;

  // Power mode codes
  typedef enum logic [2:0]
  {
    RSWK_MODE_RUN  = 3'h0,
    RSWK_MODE_WAIT = 3'h1,
    RSWK_MODE_VERY_LOW_POWER_WAIT = 3'h2,
    RSWK_MODE_STOP = 3'h3,
    RSWK_MODE_VERY_LOW_POWER_STOP = 3'h4
  } rswk_mode_t;

endpackage : rswk_pkg

//--- src/rswk_srf.sv
/*
  Always-powered scratch register file, cleared only by power-on reset.
  Assumes por_b is the power-on reset alone; read data are registered.
*/
`timescale 1ns/10ps
module rswk_srf #(
  parameter int DW = rswk_pkg::SRF_DW,
  parameter int AW = rswk_pkg::SRF_AW,
  parameter int NW = rswk_pkg::SRF_WORDS
) (
  input  wire logic          clk,
  input  wire logic          por_b,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] rd_data_q
);

  logic [DW-1:0] mem_q [NW];
  logic [DW-1:0] mem_d [NW];
  logic [DW-1:0] rd_data_d;

  always_comb
  begin
    mem_d = mem_q;
    if (wr_en)
    begin
      mem_d[addr] = wr_data;
    end
    rd_data_d = mem_q[addr];
  end

  // Only power-on reset reaches this storage
  always_ff @(posedge clk or negedge por_b)
  begin
    if (!por_b)
    begin
      for (int i = 0; i < NW; i++)
      begin
        mem_q[i] <= rswk_pkg::SRF_RESET; // R23
      end
      rd_data_q <= rswk_pkg::SRF_RESET;
    end
    else
    begin
      mem_q     <= mem_d; // R22
      rd_data_q <= rd_data_d;
    end
  end

endmodule : rswk_srf

//--- src/rswk_wake.sv
/*
  Stop-mode wake detector: qualifies each wake source and merges them.
  Assumes events are levels held by their sources until serviced.
*/
`timescale 1ns/10ps
module rswk_wake #(
  parameter int NW = rswk_pkg::NUM_WK
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          in_stop,
  input  wire logic [NW-1:0] wake_evt,
  input  wire logic [NW-1:0] wake_qual,
  output logic               wake_req_q,
  output logic [NW-1:0]      wake_src_q
);

  logic          wake_req_d;
  logic [NW-1:0] wake_src_d;
  logic [NW-1:0] hit;

  always_comb
  begin
    hit        = wake_evt & wake_qual;
    wake_req_d = in_stop && (|hit); // R24
    wake_src_d = wake_src_q;
    if (wake_req_d)
    begin
      wake_src_d = hit;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_req_q <= 1'b0;
      wake_src_q <= '0;
    end
    else
    begin
      wake_req_q <= wake_req_d;
      wake_src_q <= wake_src_d;
    end
  end

endmodule : rswk_wake

//--- src/rswk_top.sv
/*
  Reset distribution and stop-mode wake control.
  Assumes reset source requests are levels synchronous to clk and that the
  clock control logic gates the clock off only after wake_req falls.
*/
// Overview of operation
// R01: Power-on resets every domain, asserts pin.
// R02: Voltage reset spares clock, partial power domain.
// R03: Leakage wake spares power, mode, wake, clocks.
// R04: Other system resets partial, spare clock, timer.
// R05: Pin reset full reset-unit; others partial.
// R06: Voltage select fields survive non-power-on resets.
// R07: Leakage wake asserts pin only for pin wake.
// R08: Partial mode reset keeps mode registers.
// R09: Partial reset-unit reset keeps filter registers.
// R10: Stop-mode events request clocking to resume.
// R11: Interrupt controller handles still-pending interrupt.
// R12: Wake works from stop and very-low-power stop.
// R13: Pin wakes if filter off or oscillator-clocked.
// R14: Watchdog wakes only while clock enabled.
// R15: Voltage detect and warning wake from stop.
// R16: Enabled port pin interrupts wake system.
// R17: Converter wakes only on internal/crystal clock.
// R18: Comparator wakes in normal and triggered mode.
// R19: Clock alarm and seconds interrupts wake.
// R20: Clocked peripherals' enabled interrupts wake system.
// R21: Interrupt controller wakes from wait modes.
// R22: Thirty-two byte register file always powered.
// R23: Register file cleared only by power-on.
// R24: Any qualified wake source alone restarts clocking.
`timescale 1ns/10ps
module rswk_top (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic [rswk_pkg::NUM_SRC-1:0]   rst_src,
  input  wire logic                           llwake_by_pin,
  input  wire rswk_pkg::rswk_mode_t           power_mode,
  input  wire logic                           irq_pending,
  input  wire logic                           pin_filter_en,
  input  wire logic                           pin_filter_lpo,
  input  wire logic                           wdog_clk_en,
  input  wire logic                           adc_clk_ok,
  input  wire logic                           serial_clk_on,
  input  wire logic                           timer_clk_on,
  input  wire logic                           low_power_timer_clk_on,
  input  wire logic                           flex_clk_on,
  input  wire logic                           usb_clk_on,
  input  wire logic [rswk_pkg::NUM_WK-1:0]    wake_evt,
  input  wire logic                           srf_wr_en,
  input  wire logic [rswk_pkg::SRF_AW-1:0]    srf_addr,
  input  wire logic [rswk_pkg::SRF_DW-1:0]    srf_wr_data,
  output logic      [rswk_pkg::SRF_DW-1:0]    srf_rd_data_q,
  output logic      [rswk_pkg::NUM_DOM-1:0]   dom_full_rst_q,
  output logic      [rswk_pkg::NUM_DOM-1:0]   dom_part_rst_q,
  output logic                                keep_lv_select_q,
  output logic                                keep_mode_regs_q,
  output logic                                keep_filter_regs_q,
  output logic                                reset_pin_q,
  output logic                                reset_pin_oe_b_q,
  output logic                                wake_req_q,
  output logic      [rswk_pkg::NUM_WK-1:0]    wake_src_q,
  output logic                                core_wake_q
);

  logic [rswk_pkg::NUM_DOM-1:0] dom_full_d;
  logic [rswk_pkg::NUM_DOM-1:0] dom_part_d;
  logic                         keep_lv_d;
  logic                         keep_mode_d;
  logic                         keep_filt_d;
  logic                         pin_d;
  logic                         core_wake_d;
  logic                         in_stop;
  logic                         in_wait;
  logic [rswk_pkg::NUM_WK-1:0]  wake_qual;
  logic                         por_b;

  // Any of the ordinary system resets that share one column pattern, the pin reset differing only in the reset-unit column
  function automatic logic sys_group(input logic [rswk_pkg::NUM_SRC-1:0] s);
    sys_group = s[rswk_pkg::SRC_PIN]  | s[rswk_pkg::SRC_WDOG]   |
                s[rswk_pkg::SRC_SACK] | s[rswk_pkg::SRC_SW]     |
                s[rswk_pkg::SRC_LOCKUP] | s[rswk_pkg::SRC_DAP]  |
                s[rswk_pkg::SRC_DEBUG];
  endfunction : sys_group

  // Reset mapping; a domain hit both fully and partially takes the full reset
  always_comb
  begin
    dom_full_d  = '0;
    dom_part_d  = '0;
    pin_d       = 1'b0;
    if (rst_src[rswk_pkg::SRC_POR])
    begin
      dom_full_d = '1; // R01
      pin_d      = 1'b1; // R01
    end
    if (rst_src[rswk_pkg::SRC_LVD])
    begin
      dom_full_d = dom_full_d | ~(rswk_pkg::NUM_DOM'(1) << rswk_pkg::DOM_RTC)
                   & ~(rswk_pkg::NUM_DOM'(1) << rswk_pkg::DOM_PWR); // R02
      dom_part_d[rswk_pkg::DOM_PWR] = 1'b1; // R02
      pin_d = 1'b1; // R02
    end
    if (rst_src[rswk_pkg::SRC_LLWAKE])
    begin
      dom_full_d[rswk_pkg::DOM_RST]   = 1'b1; // R03
      dom_full_d[rswk_pkg::DOM_OTHER] = 1'b1; // R03
      dom_part_d[rswk_pkg::DOM_SYS]   = 1'b1; // R03
      if (llwake_by_pin)
      begin
        pin_d = 1'b1; // R07
      end
    end
    if (sys_group(rst_src))
    begin
      dom_part_d[rswk_pkg::DOM_PWR]   = 1'b1; // R04
      dom_part_d[rswk_pkg::DOM_SYS]   = 1'b1; // R04
      dom_part_d[rswk_pkg::DOM_MODE]  = 1'b1; // R04
      dom_full_d[rswk_pkg::DOM_WAKE]  = 1'b1; // R04
      dom_full_d[rswk_pkg::DOM_OTHER] = 1'b1; // R04
      pin_d = 1'b1; // R04
      if (rst_src[rswk_pkg::SRC_PIN])
      begin
        dom_full_d[rswk_pkg::DOM_RST] = 1'b1; // R05
      end
      else
      begin
        dom_part_d[rswk_pkg::DOM_RST] = 1'b1; // R05
      end
    end
    dom_part_d = dom_part_d & ~dom_full_d;
    keep_lv_d   = dom_part_d[rswk_pkg::DOM_PWR]; // R06
    keep_mode_d = dom_part_d[rswk_pkg::DOM_MODE]; // R08
    keep_filt_d = dom_part_d[rswk_pkg::DOM_RST]; // R09
  end

  // Wake qualification per source
  always_comb
  begin
    in_stop = (power_mode == rswk_pkg::RSWK_MODE_STOP) ||
              (power_mode == rswk_pkg::RSWK_MODE_VERY_LOW_POWER_STOP); // R12
    in_wait = (power_mode == rswk_pkg::RSWK_MODE_WAIT) ||
              (power_mode == rswk_pkg::RSWK_MODE_VERY_LOW_POWER_WAIT);
    wake_qual = '1; // R16 R18 R19
    wake_qual[rswk_pkg::WK_PIN]    = !pin_filter_en || pin_filter_lpo; // R13
    wake_qual[rswk_pkg::WK_WDOG]   = wdog_clk_en; // R14
    wake_qual[rswk_pkg::WK_LVD]    = 1'b1; // R15
    wake_qual[rswk_pkg::WK_LVW]    = 1'b1; // R15
    wake_qual[rswk_pkg::WK_ADC]    = adc_clk_ok; // R17
    wake_qual[rswk_pkg::WK_SERIAL] = serial_clk_on; // R20
    wake_qual[rswk_pkg::WK_TIMER]  = timer_clk_on; // R20
    wake_qual[rswk_pkg::WK_LOW_POWER_TIMER]  = low_power_timer_clk_on; // R20
    wake_qual[rswk_pkg::WK_FLEX]   = flex_clk_on; // R20
    wake_qual[rswk_pkg::WK_USB]    = usb_clk_on; // R20
    core_wake_d = in_wait && irq_pending; // R21
  end

  // Detector of stop-mode wake events
  rswk_wake #(
    .NW (rswk_pkg::NUM_WK)
  ) u_wake (
    .clk        (clk),
    .rst_b      (rst_b),
    .in_stop    (in_stop),
    .wake_evt   (wake_evt),
    .wake_qual  (wake_qual),
    .wake_req_q (wake_req_q), // R10
    .wake_src_q (wake_src_q)
  );

  // Power-on reset for always-powered storage: async reset or source bit
  assign por_b = rst_b & ~rst_src[rswk_pkg::SRC_POR];

  rswk_srf #(
    .DW (rswk_pkg::SRF_DW),
    .AW (rswk_pkg::SRF_AW),
    .NW (rswk_pkg::SRF_WORDS)
  ) u_srf (
    .clk       (clk),
    .por_b     (por_b),
    .wr_en     (srf_wr_en),
    .addr      (srf_addr),
    .wr_data   (srf_wr_data),
    .rd_data_q (srf_rd_data_q)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dom_full_rst_q     <= '1;
      dom_part_rst_q     <= '0;
      keep_lv_select_q   <= 1'b0;
      keep_mode_regs_q   <= 1'b0;
      keep_filter_regs_q <= 1'b0;
      reset_pin_q        <= 1'b0;
      reset_pin_oe_b_q   <= 1'b0;
      core_wake_q        <= 1'b0;
    end
    else
    begin
      dom_full_rst_q     <= dom_full_d;
      dom_part_rst_q     <= dom_part_d;
      keep_lv_select_q   <= keep_lv_d;
      keep_mode_regs_q   <= keep_mode_d;
      keep_filter_regs_q <= keep_filt_d;
      reset_pin_q        <= 1'b0;
      reset_pin_oe_b_q   <= ~pin_d;
      core_wake_q        <= core_wake_d; // R11
    end
  end

endmodule : rswk_top

//--- verification/rswk_top_properties.sv
/*
  Port checker for the reset map and wake detector of rswk_top.
  Assumes one clock, clk, and the asynchronous reset rst_b.
*/
`timescale 1ns/10ps
module rswk_top_properties (
  input wire logic                         clk,
  input wire logic                         rst_b,
  input wire logic [rswk_pkg::NUM_SRC-1:0] rst_src,
  input wire logic                         llwake_by_pin,
  input wire rswk_pkg::rswk_mode_t         power_mode,
  input wire logic                         irq_pending,
  input wire logic [rswk_pkg::NUM_WK-1:0]  wake_evt,
  input wire logic [rswk_pkg::SRF_DW-1:0]  srf_rd_data_q,
  input wire logic [rswk_pkg::NUM_DOM-1:0] dom_full_rst_q,
  input wire logic [rswk_pkg::NUM_DOM-1:0] dom_part_rst_q,
  input wire logic                         keep_lv_select_q,
  input wire logic                         keep_mode_regs_q,
  input wire logic                         keep_filter_regs_q,
  input wire logic                         reset_pin_oe_b_q,
  input wire logic                         wake_req_q,
  input wire logic                         core_wake_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_stop;
    power_mode inside {rswk_pkg::RSWK_MODE_STOP, rswk_pkg::RSWK_MODE_VERY_LOW_POWER_STOP};
  endsequence
  sequence s_sys_only;
    rst_src[2:0] == 3'h0 && |rst_src[9:3];
  endsequence
  a_por_full_all: assert property (rst_src[0] |=> &dom_full_rst_q && !reset_pin_oe_b_q)
    else $error("power-on left a domain or the pin free");
  a_lvd_spares_rtc: assert property (rst_src[1:0] == 2'h2 |=> dom_part_rst_q[0] &&
    !dom_full_rst_q[5] && !dom_part_rst_q[5]) else $error("voltage reset map wrong");
  a_llw_spares_set: assert property (rst_src == 10'h004 |=>
    (dom_full_rst_q & 8'h75) == 8'h00 && dom_full_rst_q[3]) else $error("leak wake map wrong");
  a_llw_pin_gate: assert property (rst_src == 10'h004 |=>
    reset_pin_oe_b_q == !$past(llwake_by_pin)) else $error("leak wake pin wrong");
  a_sys_spares_timers: assert property (s_sys_only |=> dom_full_rst_q[6:4] == 3'h1 &&
    dom_part_rst_q[2:0] == 3'h7 && !reset_pin_oe_b_q) else $error("system reset map wrong");
  a_unit_pin_full: assert property (s_sys_only |=> dom_full_rst_q[3] == $past(rst_src[3]) &&
    dom_part_rst_q[3] == !$past(rst_src[3])) else $error("reset unit depth wrong");
  a_keep_follow: assert property ({keep_lv_select_q, keep_mode_regs_q, keep_filter_regs_q} ==
    {dom_part_rst_q[0], dom_part_rst_q[2], dom_part_rst_q[3]}) else $error("keep flags wrong");
  a_wake_voltage: assert property (s_stop ##0 (|wake_evt[3:2]) |=> wake_req_q)
    else $error("voltage event did not wake");
  a_core_wait: assert property (power_mode inside {rswk_pkg::RSWK_MODE_WAIT,
    rswk_pkg::RSWK_MODE_VERY_LOW_POWER_WAIT} && irq_pending |=> core_wake_q) else $error("wait not woken");
  a_srf_por_clear: assert property (rst_src[0] |=> srf_rd_data_q == 32'h0000_0000)
    else $error("scratch file not cleared");
endmodule : rswk_top_properties

//--- verification/rswk_sys_model.sv
/*
  Far side model: clock control and interrupt controller around the block.
  Assumes wake_req_q and core_wake_q come from rswk_top.
*/
`timescale 1ns/10ps
module rswk_sys_model (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire rswk_pkg::rswk_mode_t mode_cmd,
  input  wire logic                 mode_load,
  input  wire logic                 irq_in,
  input  wire logic                 slow,
  input  wire logic                 wake_req_q,
  input  wire logic                 core_wake_q,
  output rswk_pkg::rswk_mode_t      power_mode,
  output logic                      irq_pending
);
  int unsigned wait_cnt;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      power_mode  <= rswk_pkg::RSWK_MODE_RUN;
      irq_pending <= 1'b0;
      wait_cnt    <= 0;
    end
    else
    begin
      // Pending until serviced once clocks run again
      irq_pending <= irq_in || (irq_pending && power_mode != rswk_pkg::RSWK_MODE_RUN);
      if (wake_req_q || core_wake_q)
      begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= (slow ? 5 : 0))
          power_mode <= rswk_pkg::RSWK_MODE_RUN;
      end
      else
      begin
        wait_cnt <= 0;
        if (mode_load)
          power_mode <= mode_cmd;
      end
    end
  end
endmodule : rswk_sys_model

//--- verification/test_reset_and_stop_wake_control.sv
/*
  Self-checking bench: cycle model of the reset map, wake and scratch file.
  Assumes rswk_top, rswk_sys_model and the checker are compiled first.
*/
`timescale 1ns/10ps
module test_reset_and_stop_wake_control;
  logic                 clk, rst_b, llwake_by_pin, srf_wr_en, mode_load, irq_in, slow;
  logic                 irq_pending, keep_lv_select_q, keep_mode_regs_q, keep_filter_regs_q;
  logic                 reset_pin_q, reset_pin_oe_b_q, wake_req_q, core_wake_q;
  logic [1:0]           pf;
  logic [6:0]           qual;
  logic [9:0]           rst_src;
  logic [13:0]          wake_evt, wake_src_q;
  logic [2:0]           srf_addr;
  logic [31:0]          srf_wr_data, srf_rd_data_q;
  logic [7:0]           dom_full_rst_q, dom_part_rst_q;
  rswk_pkg::rswk_mode_t power_mode, mode_cmd;
  logic [31:0]          mem [8];
  int                   failures, num_checks;

  rswk_top u_dut (.clk, .rst_b, .rst_src, .llwake_by_pin, .power_mode, .irq_pending,
    .pin_filter_en(pf[0]), .pin_filter_lpo(pf[1]), .wdog_clk_en(qual[0]), .adc_clk_ok(qual[1]),
    .serial_clk_on(qual[2]), .timer_clk_on(qual[3]), .low_power_timer_clk_on(qual[4]),
    .flex_clk_on(qual[5]), .usb_clk_on(qual[6]), .wake_evt, .srf_wr_en, .srf_addr, .srf_wr_data,
    .srf_rd_data_q, .dom_full_rst_q, .dom_part_rst_q, .keep_lv_select_q, .keep_mode_regs_q,
    .keep_filter_regs_q, .reset_pin_q, .reset_pin_oe_b_q, .wake_req_q, .wake_src_q, .core_wake_q);
  rswk_sys_model u_sys (.clk, .rst_b, .mode_cmd, .mode_load, .irq_in, .slow, .wake_req_q,
    .core_wake_q, .power_mode, .irq_pending);

  always #4 clk = ~clk;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wait_run();
    int n;
    n = 0;
    while (power_mode !== rswk_pkg::RSWK_MODE_RUN && n < 20)
    begin
      step();
      n++;
    end
    if (power_mode !== rswk_pkg::RSWK_MODE_RUN)
    begin
      failures++;
      wrap_up();
    end
  endtask : wait_run

  // Expectation from the inputs seen at each edge, compared once outputs settle
  always @(posedge clk)
  begin : ref_model
    logic [7:0]  f, p;
    logic [13:0] q;
    logic [31:0] rd;
    logic        pa, ws, wk, rdok;
    f = {8{rst_src[0]}} | {8{rst_src[1]}} & 8'hDE | {8{rst_src[2]}} & 8'h88 |
      {8{|rst_src[9:3]}} & 8'h90 | {4'h0, rst_src[3], 3'h0};
    p = ({7'h0, rst_src[1]} | {6'h0, rst_src[2], 1'b0} | {5'h0, {3{|rst_src[9:3]}}} |
      {4'h0, |rst_src[9:4], 3'h0}) & ~f;
    pa = rst_src[0] | rst_src[1] | |rst_src[9:3] | rst_src[2] & llwake_by_pin;
    q = wake_evt & {qual[6:2], 3'h7, qual[1], 3'h7, qual[0], !pf[0] || pf[1]};
    ws = power_mode inside {rswk_pkg::RSWK_MODE_STOP, rswk_pkg::RSWK_MODE_VERY_LOW_POWER_STOP} && |q;
    wk = power_mode inside {rswk_pkg::RSWK_MODE_WAIT, rswk_pkg::RSWK_MODE_VERY_LOW_POWER_WAIT} && irq_pending;
    rdok = !srf_wr_en;
    rd = rst_src[0] ? 32'h0000_0000 : mem[srf_addr];
    if (!rst_b || rst_src[0])
      mem = '{default: 32'h0000_0000};
    else if (srf_wr_en)
      mem[srf_addr] = srf_wr_data;
    #0.5;
    if (rst_b)
    begin
      chk({dom_full_rst_q, dom_part_rst_q, keep_lv_select_q, keep_mode_regs_q, keep_filter_regs_q,
        reset_pin_oe_b_q, reset_pin_q}, {f, p, p[0], p[2], p[3], !pa, 1'b0});
      chk({wake_req_q, core_wake_q}, {ws, wk});
      if (ws)
        chk(wake_src_q, q);
      if (rdok)
        chk(srf_rd_data_q, rd);
    end
  end

  initial
  begin
    {clk, rst_b, llwake_by_pin, srf_wr_en, mode_load, irq_in, slow} = '0;
    {pf, rst_src, wake_evt, srf_addr, srf_wr_data} = '0;
    qual = '1;
    mode_cmd = rswk_pkg::RSWK_MODE_RUN;
    failures = 0;
    num_checks = 0;
    void'($urandom(32'h6049db75));
    step(5);
    rst_b = 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      rst_src = 10'h001 << (i % 10);
      llwake_by_pin = 1'(i / 10);
      step();
    end
    rst_src = '0;
    $display("reset source map test done");
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        srf_wr_en = (r == 0);
        srf_addr = 3'(i);
        srf_wr_data = $urandom;
        step();
      end
      srf_wr_en = 1'b0;
      rst_src = (r == 1) ? 10'h001 : 10'h040;
      step();
      rst_src = '0;
    end
    $display("scratch file test done");
    for (int i = 0; i < 28; i++)
    begin
      mode_cmd = (i < 14) ? rswk_pkg::RSWK_MODE_STOP : rswk_pkg::RSWK_MODE_VERY_LOW_POWER_STOP;
      mode_load = 1'b1;
      slow = 1'(i);
      step();
      mode_load = 1'b0;
      step();
      wake_evt = 14'h0001 << (i % 14);
      wait_run();
      wake_evt = '0;
      step();
    end
    $display("wake source test done");
    repeat (3000)
    begin
      rst_src = ($urandom % 8 == 0) ? 10'($urandom) : '0;
      llwake_by_pin = 1'($urandom);
      pf = 2'($urandom);
      qual = 7'($urandom);
      wake_evt = 14'($urandom & $urandom & $urandom);
      mode_cmd = rswk_pkg::rswk_mode_t'($urandom % 5);
      mode_load = ($urandom % 6 == 0);
      irq_in = ($urandom % 4 == 0);
      slow = 1'($urandom);
      srf_wr_en = 1'($urandom);
      srf_addr = 3'($urandom);
      srf_wr_data = $urandom;
      step();
    end
    $display("random mix test done");
    wrap_up();
  end
endmodule : test_reset_and_stop_wake_control

bind rswk_top rswk_top_properties u_chk (.clk, .rst_b, .rst_src, .llwake_by_pin, .power_mode,
  .irq_pending, .wake_evt, .srf_rd_data_q, .dom_full_rst_q, .dom_part_rst_q, .keep_lv_select_q,
  .keep_mode_regs_q, .keep_filter_regs_q, .reset_pin_oe_b_q, .wake_req_q, .core_wake_q);
